/* File: rtl/aemps_ctrl.v */
// Purpose: External analog mux select control and parallel-conversion sync
// Assumes: Arbiter outside issues conversion starts and aborts; peer kernel
//          signals arrive asynchronously and are synchronised here
// Notes:   Notes on behaviour
//
// Notes on behaviour
// - Three select outputs drive external mux.
// - Conversion start copies pending select to current.
// - Per-channel enable zero to seven; clear leaves select.
// - Select change forces alternative sample phase once.
// - Aborted first conversion repeats with alternative phase.
// - Alternative phase is two plus extension cycles.
// - Control register layout; bits 3, 7 zero.
// - Master forwards sync channel requests; slaves never.
// - Slave runs own requests when master idle.
// - Started parallel conversion is never aborted.
// - Slave gives parallel request top priority, cancel-inject.
// - Wait-for-read honoured only in master.
// - Master distributes power state and channel number.
// - Ready output; evaluate-ready waits for all ready.
// - Parallel sample phases start together everywhere.
// - One master defines clocks and channel.
// - Slave redirects received channel through alias.
// - Reserved start-select codes switch kernel off.
`timescale 1ns/1ps
`include "aemps_regs.vh"

module aemps_ctrl #(
    parameter NPEER = 1
) (
    // Clock and reset
    input  wire              i_clk,
    input  wire              i_rstn,
    // APB slave
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [13:0]       paddr,
    input  wire [31:0]       pwdata,
    output wire              pready,
    output wire [31:0]       prdata,
    output wire              pslverr,
    // Analog clock enable and kernel arbiter
    input  wire              i_aclk_en,
    input  wire              i_conv_start,
    input  wire [3:0]        i_conv_chan,
    input  wire              i_conv_sync,
    input  wire              i_conv_abort,
    input  wire              i_conv_done,
    input  wire              i_local_ready,
    input  wire [3:0]        i_alias_map,
    // External mux
    output wire [2:0]        o_mux_select_out,
    // Sample phase control
    output wire              o_use_alt_sample,
    output wire              o_sample_active,
    output wire              o_sample_done,
    // Sync group link
    input  wire [1:0]        i_master_control_input,
    input  wire              i_master_req,
    input  wire [3:0]        i_master_chan,
    input  wire [NPEER-1:0]  i_peer_ready_input,
    output reg  [1:0]        o_power_state_out,
    output reg               o_sync_req_out,
    output reg  [3:0]        o_sync_chan_out,
    output wire              o_ready,
    // Toward the kernel arbiter
    output wire              o_kernel_off,
    output wire              o_slave_inject,
    output reg  [3:0]        o_slave_chan,
    output wire              o_abort_allowed,
    output wire              o_wait_for_read_en,
    output wire              o_start_parallel
);

// ----------------------------------------
// Registers
// ----------------------------------------
reg  [2:0]  pending_select_reg;
reg  [2:0]  current_select_reg;
reg  [7:0]  alt_sample_extension_reg;
reg  [7:0]  channel_mux_ctrl_en_reg;
reg  [1:0]  start_source_select_reg;
reg         evaluate_peer_ready_reg;
reg  [1:0]  converter_power_state_reg;
reg         wfr_reg;
reg         settle_pend_reg;
reg         alt_conv_reg;
reg         par_conv_reg;
reg  [8:0]  sample_cnt_reg;
reg         sample_act_reg;
reg  [31:0] prdata_reg;
reg  [1:0]  mci_s1_reg;
reg  [1:0]  mci_s2_reg;
reg         mreq_s1_reg;
reg         mreq_s2_reg;
reg  [3:0]  mch_s1_reg;
reg  [3:0]  mch_s2_reg;
reg  [NPEER-1:0] prdy_s1_reg;
reg  [NPEER-1:0] prdy_s2_reg;

wire        is_master = (start_source_select_reg == `AEMPS_START_SOURCE_SELECT_MASTER);
wire        is_slave  = (start_source_select_reg == `AEMPS_START_SOURCE_SELECT_SLAVE);
wire        wr_en     = psel & penable & pwrite;
// Read data loads in the setup cycle so it stands through the access phase
wire        rd_en     = psel & ~penable & ~pwrite;
wire        chan_low  = ~i_conv_chan[3];
wire        mux_en    = chan_low & channel_mux_ctrl_en_reg[i_conv_chan[2:0]];
wire        mux_start = i_conv_start & mux_en;
wire        sel_chg   = mux_start & (pending_select_reg != current_select_reg);
wire        grp_ready = i_local_ready & (&prdy_s2_reg);
wire [1:0]  eff_power = is_slave ? mci_s2_reg : converter_power_state_reg;
wire [8:0]  alt_len   = `AEMPS_ALT_BASE + {1'b0, alt_sample_extension_reg};

function addr_hit;
    input [13:0] a;
    input [13:0] ref_a;
    begin
        addr_hit = (a == ref_a);
    end
endfunction

// ----------------------------------------
// APB slave
// ----------------------------------------
assign pready  = 1'b1;
assign prdata  = prdata_reg;
assign pslverr = psel & penable & ~(addr_hit(paddr, `AEMPS_ADDR_MUX_SELECT_OUT_CTRL)
                 | addr_hit(paddr, `AEMPS_ADDR_MUX_SELECT_OUT_EN)
                 | addr_hit(paddr, `AEMPS_ADDR_SYNC_CTRL)
                 | addr_hit(paddr, `AEMPS_ADDR_KERNEL_CTRL)
                 | addr_hit(paddr, `AEMPS_ADDR_KERNEL_STAT));

always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        pending_select_reg        <= 3'h0;
        alt_sample_extension_reg  <= 8'h00;
        channel_mux_ctrl_en_reg   <= 8'h00;
        start_source_select_reg   <= 2'h0;
        evaluate_peer_ready_reg   <= 1'b0;
        converter_power_state_reg <= 2'h0;
        wfr_reg                   <= 1'b0;
        prdata_reg                <= 32'h00000000;
    end else begin
        if (wr_en && addr_hit(paddr, `AEMPS_ADDR_MUX_SELECT_OUT_CTRL)) begin
            pending_select_reg       <= pwdata[2:0];
            alt_sample_extension_reg <= pwdata[15:8];
        end
        if (wr_en && addr_hit(paddr, `AEMPS_ADDR_MUX_SELECT_OUT_EN)) begin
            channel_mux_ctrl_en_reg <= {pwdata[14], pwdata[12], pwdata[10], pwdata[8],
                                        pwdata[6], pwdata[4], pwdata[2], pwdata[0]};
        end
        if (wr_en && addr_hit(paddr, `AEMPS_ADDR_SYNC_CTRL)) begin
            start_source_select_reg <= pwdata[1:0];
            evaluate_peer_ready_reg <= pwdata[4];
        end
        if (wr_en && addr_hit(paddr, `AEMPS_ADDR_KERNEL_CTRL)) begin
            converter_power_state_reg <= pwdata[1:0];
            wfr_reg                   <= pwdata[2];
        end
        if (rd_en) begin
            prdata_reg <= 32'h00000000;
            if (addr_hit(paddr, `AEMPS_ADDR_MUX_SELECT_OUT_CTRL))
                prdata_reg[15:0] <= {alt_sample_extension_reg, 1'b0,
                                     current_select_reg, 1'b0, pending_select_reg};
            else if (addr_hit(paddr, `AEMPS_ADDR_MUX_SELECT_OUT_EN))
                prdata_reg[15:0] <= {1'b0, channel_mux_ctrl_en_reg[7], 1'b0,
                                     channel_mux_ctrl_en_reg[6], 1'b0,
                                     channel_mux_ctrl_en_reg[5], 1'b0,
                                     channel_mux_ctrl_en_reg[4], 1'b0,
                                     channel_mux_ctrl_en_reg[3], 1'b0,
                                     channel_mux_ctrl_en_reg[2], 1'b0,
                                     channel_mux_ctrl_en_reg[1], 1'b0,
                                     channel_mux_ctrl_en_reg[0]};
            else if (addr_hit(paddr, `AEMPS_ADDR_SYNC_CTRL))
                prdata_reg[15:0] <= {11'h000, evaluate_peer_ready_reg, 2'h0,
                                     start_source_select_reg};
            else if (addr_hit(paddr, `AEMPS_ADDR_KERNEL_CTRL))
                prdata_reg[15:0] <= {13'h0000, wfr_reg, converter_power_state_reg};
            else if (addr_hit(paddr, `AEMPS_ADDR_KERNEL_STAT))
                prdata_reg[15:0] <= {8'h00, par_conv_reg, settle_pend_reg,
                                     sample_act_reg, grp_ready, eff_power, 2'h0};
        end
    end
end

// ----------------------------------------
// Peer input synchronisers
// ----------------------------------------
always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        mci_s1_reg  <= 2'h0;
        mci_s2_reg  <= 2'h0;
        mreq_s1_reg <= 1'b0;
        mreq_s2_reg <= 1'b0;
        mch_s1_reg  <= 4'h0;
        mch_s2_reg  <= 4'h0;
        prdy_s1_reg <= {NPEER{1'b0}};
        prdy_s2_reg <= {NPEER{1'b0}};
    end else begin
        mci_s1_reg  <= i_master_control_input;
        mci_s2_reg  <= mci_s1_reg;
        mreq_s1_reg <= i_master_req;
        mreq_s2_reg <= mreq_s1_reg;
        // Channel is held stable by the master while its request stands
        mch_s1_reg  <= i_master_chan;
        mch_s2_reg  <= mch_s1_reg;
        prdy_s1_reg <= i_peer_ready_input;
        prdy_s2_reg <= prdy_s1_reg;
    end
end

// ----------------------------------------
// External mux select and settling
// ----------------------------------------
always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        current_select_reg <= 3'h0;
        settle_pend_reg    <= 1'b0;
        alt_conv_reg       <= 1'b0;
    end else begin
        if (mux_start) begin
            current_select_reg <= pending_select_reg;
            alt_conv_reg       <= sel_chg | settle_pend_reg;
        end else if (i_conv_start) begin
            alt_conv_reg <= 1'b0;
        end
        // Settling ends only on a complete conversion, so aborts keep it
        if (sel_chg)
            settle_pend_reg <= 1'b1;
        else if (i_conv_done && alt_conv_reg)
            settle_pend_reg <= 1'b0;
    end
end

assign o_mux_select_out = current_select_reg;
assign o_use_alt_sample = alt_conv_reg;

// ----------------------------------------
// Alternative sample phase timer
// ----------------------------------------
always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        sample_cnt_reg <= 9'h000;
        sample_act_reg <= 1'b0;
    end else if (mux_start && (sel_chg || settle_pend_reg)) begin
        sample_cnt_reg <= alt_len;
        sample_act_reg <= 1'b1;
    end else if (i_conv_abort && !par_conv_reg) begin
        sample_act_reg <= 1'b0;
    end else if (sample_act_reg && i_aclk_en) begin
        sample_cnt_reg <= sample_cnt_reg - 9'h001;
        if (sample_cnt_reg == 9'h001)
            sample_act_reg <= 1'b0;
    end
end

assign o_sample_active = sample_act_reg;
assign o_sample_done   = sample_act_reg & i_aclk_en & (sample_cnt_reg == 9'h001);

// ----------------------------------------
// Synchronised parallel conversions
// ----------------------------------------
always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        o_power_state_out <= 2'h0;
        o_sync_req_out    <= 1'b0;
        o_sync_chan_out   <= 4'h0;
        o_slave_chan      <= 4'h0;
        par_conv_reg      <= 1'b0;
    end else begin
        o_power_state_out <= is_master ? converter_power_state_reg : 2'h0;
        if (is_master && i_conv_start && i_conv_sync) begin
            o_sync_req_out  <= 1'b1;
            o_sync_chan_out <= i_conv_chan;
        end else if (!is_master || i_conv_done) begin
            o_sync_req_out <= 1'b0;
        end
        if (is_slave && mreq_s2_reg)
            o_slave_chan <= mch_s2_reg ^ i_alias_map;
        if (o_start_parallel)
            par_conv_reg <= 1'b1;
        else if (i_conv_done)
            par_conv_reg <= 1'b0;
    end
end

assign o_kernel_off       = ~is_master & ~is_slave;
assign o_slave_inject     = is_slave & mreq_s2_reg & (eff_power != 2'h0);
assign o_abort_allowed    = ~par_conv_reg;
assign o_wait_for_read_en = wfr_reg & is_master;
assign o_ready            = i_local_ready & ~o_kernel_off;
// Slave own requests proceed while o_slave_inject is low
assign o_start_parallel   = ~o_kernel_off & ~par_conv_reg
                            & ((is_master & o_sync_req_out) | o_slave_inject)
                            & (~evaluate_peer_ready_reg | grp_ready);

endmodule // aemps_ctrl

/* File: rtl/aemps_regs.vh */
// Purpose: Offsets, fields, reset values and timing for the mux/sync block
// Assumes: APB word access, byte address = register index * 4
// Notes:   Printed offsets 0xD0 and 0xD6 are not both multiples of four,
//          so offsets are kept as indices and the byte address is index * 4
`ifndef AEMPS_REGS_VH
`define AEMPS_REGS_VH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define AEMPS_IDX_MUX_SELECT_OUT_CTRL     12'h0D0
`define AEMPS_IDX_MUX_SELECT_OUT_EN       12'h0D6
`define AEMPS_IDX_SYNC_CTRL     12'h01A
`define AEMPS_IDX_KERNEL_CTRL   12'h0E0
`define AEMPS_IDX_KERNEL_STAT   12'h0E2
`define AEMPS_ADDR_MUX_SELECT_OUT_CTRL    14'h0340
`define AEMPS_ADDR_MUX_SELECT_OUT_EN      14'h0358
`define AEMPS_ADDR_SYNC_CTRL    14'h0068
`define AEMPS_ADDR_KERNEL_CTRL  14'h0380
`define AEMPS_ADDR_KERNEL_STAT  14'h0388

// ----------------------------------------
// Field positions
// ----------------------------------------
`define AEMPS_PEND_LSB          0
`define AEMPS_CUR_LSB           4
`define AEMPS_EXT_LSB           8
`define AEMPS_SYNC_START_SOURCE_SELECT_LSB    0
`define AEMPS_SYNC_EVAL_BIT     4
`define AEMPS_KC_PWR_LSB        0
`define AEMPS_KC_WFR_BIT        2

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define AEMPS_RST_16            16'h0000
`define AEMPS_START_SOURCE_SELECT_MASTER      2'h0
`define AEMPS_START_SOURCE_SELECT_SLAVE       2'h1
`define AEMPS_ALT_BASE          9'h002

`endif

/* File: dv/aemps_ctrl_sva.sv */
// Purpose: Port checker for aemps_ctrl
// Assumes: APB writes land at the access edge
// Notes:   Shadows only the register fields the properties need
`timescale 1ns/1ps
`include "aemps_regs.vh"
module aemps_ctrl_sva #(parameter NPEER = 1) (
    input wire logic i_clk, i_rstn, psel, penable, pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic i_aclk_en, i_conv_start, i_conv_sync,
    input wire logic [3:0] i_conv_chan,
    input wire logic [NPEER-1:0] i_peer_ready_input,
    input wire logic [2:0] o_mux_select_out,
    input wire logic o_sample_active, o_sample_done, o_sync_req_out, o_kernel_off,
    input wire logic o_abort_allowed, o_wait_for_read_en, o_start_parallel
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // ----------------------------------------
    // Register shadow
    // ----------------------------------------
    logic [2:0]  pend_q;
    logic [15:0] en_q;
    logic [1:0]  start_source_select_q;
    logic        eval_q;
    wire wr    = psel && penable && pwrite;
    wire en_ok = !i_conv_chan[3] && en_q[{i_conv_chan[2:0], 1'b0}];
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pend_q  <= 3'h0;
            en_q    <= 16'h0000;
            start_source_select_q <= 2'h0;
            eval_q  <= 1'b0;
        end else if (wr) begin
            if (paddr == `AEMPS_ADDR_MUX_SELECT_OUT_CTRL) pend_q <= pwdata[2:0];
            if (paddr == `AEMPS_ADDR_MUX_SELECT_OUT_EN) en_q <= pwdata[15:0];
            if (paddr == `AEMPS_ADDR_SYNC_CTRL) start_source_select_q <= pwdata[1:0];
            if (paddr == `AEMPS_ADDR_SYNC_CTRL) eval_q <= pwdata[4];
        end
    end
    sequence s_en_start; i_conv_start && en_ok; endsequence
    sequence s_dis_start; i_conv_start && !en_ok; endsequence
    sequence s_rd_ctrl; psel && penable && !pwrite && paddr == `AEMPS_ADDR_MUX_SELECT_OUT_CTRL; endsequence
    property p_sel_copy; s_en_start |=> o_mux_select_out == pend_q; endproperty
    property p_sel_dis; s_dis_start |=> $stable(o_mux_select_out); endproperty
    property p_sel_hold; $changed(o_mux_select_out) |-> $past(i_conv_start); endproperty
    property p_zero_bits; s_rd_ctrl |-> !prdata[3] && !prdata[7] && prdata[31:16] == 0; endproperty
    property p_done_en; o_sample_done |-> i_aclk_en && o_sample_active; endproperty
    property p_sync_rise;
        $rose(o_sync_req_out) |-> $past(i_conv_start && i_conv_sync) && start_source_select_q == 2'h0;
    endproperty
    property p_off; o_kernel_off == start_source_select_q[1]; endproperty
    property p_par_wait; o_start_parallel && eval_q |-> $past(&i_peer_ready_input, 2); endproperty
    property p_no_abort; o_start_parallel |=> !o_abort_allowed; endproperty
    property p_wfr; start_source_select_q == 2'h1 |-> !o_wait_for_read_en; endproperty
    a_sel_copy: assert property (p_sel_copy) else $error("select not copied");
    a_sel_dis: assert property (p_sel_dis) else $error("disabled start moved select");
    a_sel_hold: assert property (p_sel_hold) else $error("select changed idle");
    a_zero_bits: assert property (p_zero_bits) else $error("reserved bits set");
    a_done_en: assert property (p_done_en) else $error("sample done off enable");
    a_sync_rise: assert property (p_sync_rise) else $error("bad sync request");
    a_off: assert property (p_off) else $error("kernel off mismatch");
    a_par_wait: assert property (p_par_wait) else $error("started before ready");
    a_no_abort: assert property (p_no_abort) else $error("parallel abortable");
    a_wfr: assert property (p_wfr) else $error("slave wait for read");
endmodule // aemps_ctrl_sva
bind aemps_ctrl aemps_ctrl_sva #(.NPEER(NPEER)) u_sva (
    .i_clk(i_clk), .i_rstn(i_rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .i_aclk_en(i_aclk_en),
    .i_conv_start(i_conv_start), .i_conv_sync(i_conv_sync), .i_conv_chan(i_conv_chan),
    .i_peer_ready_input(i_peer_ready_input), .o_mux_select_out(o_mux_select_out),
    .o_sample_active(o_sample_active), .o_sample_done(o_sample_done),
    .o_sync_req_out(o_sync_req_out), .o_kernel_off(o_kernel_off),
    .o_abort_allowed(o_abort_allowed), .o_wait_for_read_en(o_wait_for_read_en),
    .o_start_parallel(o_start_parallel));

/* File: dv/aemps_peer_model.sv */
// Purpose: Peer converter kernel on the sync group link
// Assumes: Bench picks the peer role and the ready delay
// Notes:   Released channel lines show the inverse so stale values never match
`timescale 1ns/1ps
module aemps_peer_model #(parameter NPEER = 1) (
    // Bench control
    input  wire logic        i_clk,
    input  wire logic        i_go,
    input  wire logic        i_master_role,
    input  wire logic [3:0]  i_chan,
    input  wire logic [3:0]  i_ready_dly,
    // Link toward the kernel
    output logic [1:0]       o_power,
    output logic             o_req,
    output logic [3:0]       o_chan,
    output logic [NPEER-1:0] o_ready
);
    logic [3:0] cnt = 4'h0;
    always @(posedge i_clk) begin
        cnt <= !i_go ? 4'h0 : (cnt == 4'hF) ? cnt : cnt + 4'h1;
        o_ready <= {NPEER{i_go && cnt >= i_ready_dly}};
        o_power <= i_master_role ? 2'h3 : 2'h0;
        o_req <= i_master_role && i_go;
        o_chan <= (i_master_role && i_go) ? i_chan : ~i_chan;
    end
endmodule // aemps_peer_model

/* File: dv/test_adc_mux_select_out_and_parallel_sync.sv */
// Purpose: Self-checking bench for aemps_ctrl
// Assumes: Read data is taken at the access edge
// Notes:   Analog clock enable runs at half the bus clock
`timescale 1ns/1ps
`include "aemps_regs.vh"
module test_adc_mux_select_out_and_parallel_sync;
    logic i_clk = 1'b0, i_rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [13:0] paddr = 14'h0000;
    logic [31:0] pwdata = 32'h0, rd;
    logic i_aclk_en = 1'b0, i_conv_start = 1'b0, i_conv_sync = 1'b0, i_conv_abort = 1'b0;
    logic i_conv_done = 1'b0, i_local_ready = 1'b1, go = 1'b0, role = 1'b0, err;
    logic [3:0] i_conv_chan = 4'h0, i_alias_map = 4'h0, pchan = 4'h0;
    wire pready, pslverr, o_use_alt_sample, o_sample_active, o_sample_done, o_sync_req_out;
    wire o_ready, o_kernel_off, o_slave_inject, o_abort_allowed, o_wait_for_read_en;
    wire o_start_parallel, i_master_req;
    wire [31:0] prdata;
    wire [2:0] o_mux_select_out;
    wire [1:0] o_power_state_out, i_master_control_input;
    wire [3:0] o_sync_chan_out, o_slave_chan, i_master_chan;
    wire [0:0] i_peer_ready_input;
    int error_cnt = 0;
    int n_compared = 0;
    int n;
    aemps_ctrl #(.NPEER(1)) dut (
        .i_clk(i_clk), .i_rstn(i_rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .i_aclk_en(i_aclk_en), .i_conv_start(i_conv_start), .i_conv_chan(i_conv_chan),
        .i_conv_sync(i_conv_sync), .i_conv_abort(i_conv_abort), .i_conv_done(i_conv_done),
        .i_local_ready(i_local_ready), .i_alias_map(i_alias_map),
        .o_mux_select_out(o_mux_select_out), .o_use_alt_sample(o_use_alt_sample),
        .o_sample_active(o_sample_active), .o_sample_done(o_sample_done),
        .i_master_control_input(i_master_control_input), .i_master_req(i_master_req),
        .i_master_chan(i_master_chan), .i_peer_ready_input(i_peer_ready_input),
        .o_power_state_out(o_power_state_out), .o_sync_req_out(o_sync_req_out),
        .o_sync_chan_out(o_sync_chan_out), .o_ready(o_ready), .o_kernel_off(o_kernel_off),
        .o_slave_inject(o_slave_inject), .o_slave_chan(o_slave_chan),
        .o_abort_allowed(o_abort_allowed), .o_wait_for_read_en(o_wait_for_read_en),
        .o_start_parallel(o_start_parallel));
    aemps_peer_model #(.NPEER(1)) u_peer (.i_clk(i_clk), .i_go(go), .i_master_role(role),
        .i_chan(pchan), .i_ready_dly(4'h2), .o_power(i_master_control_input),
        .o_req(i_master_req), .o_chan(i_master_chan), .o_ready(i_peer_ready_input));
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) i_aclk_en <= ~i_aclk_en;
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
        @(posedge i_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do @(posedge i_clk); while (pready !== 1'b1);
        err = pslverr;
        rd = prdata;
        psel <= 1'b0; penable <= 1'b0;
        @(negedge i_clk);
    endtask
    task automatic ev(input logic s, ab, dn, input logic [3:0] ch, input logic sy);
        @(posedge i_clk);
        i_conv_start <= s; i_conv_abort <= ab; i_conv_done <= dn;
        i_conv_chan <= ch; i_conv_sync <= sy;
        @(posedge i_clk);
        i_conv_start <= 1'b0; i_conv_abort <= 1'b0; i_conv_done <= 1'b0; i_conv_sync <= 1'b0;
        @(negedge i_clk);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        check(o_mux_select_out, 32'h0);
        apb(1, `AEMPS_ADDR_MUX_SELECT_OUT_CTRL, 32'hFFFF_FFFF);
        apb(0, `AEMPS_ADDR_MUX_SELECT_OUT_CTRL, 32'h0); check(rd, 32'h0000_FF07);
        apb(1, `AEMPS_ADDR_MUX_SELECT_OUT_EN, 32'h0000_AAAB);
        apb(0, `AEMPS_ADDR_MUX_SELECT_OUT_EN, 32'h0); check(rd, 32'h0000_0001);
        apb(0, 14'h0004, 32'h0); check({err, rd[30:0]}, 32'h8000_0000);
    endtask
    task automatic t_mux();
        apb(1, `AEMPS_ADDR_MUX_SELECT_OUT_EN, 32'h0000_4000);
        apb(1, `AEMPS_ADDR_MUX_SELECT_OUT_CTRL, 32'h0000_0305);
        ev(1, 0, 0, 4'h7, 0); check(o_mux_select_out, 32'h5);
        check(o_use_alt_sample, 32'h1);
        n = 0;
        repeat (100) begin
            if (o_sample_active && i_aclk_en) n++;
            if (o_sample_done) break;
            @(negedge i_clk);
        end
        check(n, 32'd5);
        ev(0, 0, 1, 4'h7, 0);
        apb(0, `AEMPS_ADDR_MUX_SELECT_OUT_CTRL, 32'h0); check(rd, 32'h0000_0355);
        ev(1, 0, 0, 4'h7, 0); check(o_use_alt_sample, 32'h0);
        ev(0, 0, 1, 4'h7, 0);
        apb(1, `AEMPS_ADDR_MUX_SELECT_OUT_CTRL, 32'h0000_0302);
        ev(1, 0, 0, 4'h3, 0); check(o_mux_select_out, 32'h5);
        ev(1, 0, 0, 4'h7, 0);
        ev(0, 1, 0, 4'h7, 0);
        ev(1, 0, 0, 4'h7, 0); check(o_use_alt_sample, 32'h1);
        ev(0, 0, 1, 4'h7, 0);
        ev(1, 0, 0, 4'h7, 0); check(o_use_alt_sample, 32'h0);
        ev(0, 0, 1, 4'h7, 0);
    endtask
    task automatic t_master();
        for (int e = 1; e >= 0; e--) begin
            apb(1, `AEMPS_ADDR_KERNEL_CTRL, 32'h0);
            apb(1, `AEMPS_ADDR_SYNC_CTRL, e ? 32'h10 : 32'h0);
            apb(1, `AEMPS_ADDR_KERNEL_CTRL, 32'h7);
            check(o_wait_for_read_en, 32'h1);
            ev(1, 0, 0, 4'h4, 1);
            check({o_sync_req_out, o_sync_chan_out, o_power_state_out}, 32'h53);
            for (n = 0; n < 30 && o_start_parallel !== 1'b1; n++) begin
                if (n == 8) go <= 1'b1;
                @(negedge i_clk);
            end
            check(n < 8, e == 0);
            check(o_start_parallel, 32'h1);
            @(negedge i_clk); check(o_abort_allowed, 32'h0);
            ev(0, 0, 1, 4'h4, 0); check(o_sync_req_out, 32'h0);
            go <= 1'b0;
        end
    endtask
    task automatic t_slave();
        apb(1, `AEMPS_ADDR_KERNEL_CTRL, 32'h4);
        apb(1, `AEMPS_ADDR_SYNC_CTRL, 32'h11);
        check({o_wait_for_read_en, o_power_state_out}, 32'h0);
        @(posedge i_clk) i_alias_map <= 4'h1;
        role <= 1'b1; pchan <= 4'h2; go <= 1'b1;
        for (n = 0; n < 12 && o_slave_inject !== 1'b1; n++) @(negedge i_clk);
        check(o_slave_inject, 32'h1);
        @(negedge i_clk); check(o_slave_chan, 32'h3);
        check(o_sync_req_out, 32'h0);
        go <= 1'b0;
        repeat (6) @(negedge i_clk);
        check({o_slave_inject, o_kernel_off}, 32'h0);
        apb(1, `AEMPS_ADDR_MUX_SELECT_OUT_CTRL, 32'h0000_0304);
        ev(1, 0, 0, 4'h7, 0); check(o_mux_select_out, 32'h4);
        ev(0, 0, 1, 4'h7, 0);
    endtask
    task automatic t_off();
        for (int s = 0; s < 4; s++) begin
            apb(1, `AEMPS_ADDR_SYNC_CTRL, s);
            check(o_kernel_off, s > 1);
            check(o_ready, s < 2);
        end
    endtask
    task automatic report_and_stop();
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge i_clk);
        i_rstn <= 1'b1;
        t_regs();
        t_mux();
        t_master();
        t_slave();
        t_off();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        error_cnt++;
        report_and_stop();
    end
endmodule // test_adc_mux_select_out_and_parallel_sync
